/* File: pdcg_clk_gate.v */
// Glitch-free clock gate with two-source selection
`default_nettype none

module pdcg_clk_gate
(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire srst_i,
  input wire ce_i,
  // Control
  input wire gate_en_i,
  input wire src_sel_i,
  input wire rst_sel_i,
  // Source clock levels, already synchronised
  input wire src0_i,
  input wire src1_i,
  // Gated clock
  output wire clk_o
);

  reg out_ff;
  reg cur_en_ff;
  reg cur_sel_ff;
  reg cand_prev_ff;
  reg nxt_out;
  wire cand_lvl = src_sel_i ? src1_i : src0_i;
  wire cand_fall = cand_prev_ff & ~cand_lvl;
  wire change = (gate_en_i != cur_en_ff) | (gate_en_i & (src_sel_i != cur_sel_ff));

  always @*
  begin
    nxt_out = cur_en_ff & (cur_sel_ff ? src1_i : src0_i);
  end

  // Old source is stopped in its low phase, new one starts at its falling edge
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      out_ff <= 1'b0;
      cur_en_ff <= 1'b0;
      cur_sel_ff <= rst_sel_i;
      cand_prev_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      cand_prev_ff <= cand_lvl;
      if (change && !out_ff && !nxt_out)
      begin
        if (cur_en_ff || !gate_en_i)
        begin
          cur_en_ff <= 1'b0;
        end
        else if (cand_fall)
        begin
          cur_en_ff <= 1'b1;
          cur_sel_ff <= src_sel_i;
        end
        out_ff <= 1'b0;
      end
      else
      begin
        out_ff <= nxt_out;
      end
    end
  end

  assign clk_o = out_ff;

endmodule

`default_nettype wire

/* File: pdcg_map.vh */
// Register map, field positions and reset values of the clock control block
`ifndef PDCG_MAP_VH
`define PDCG_MAP_VH

// Byte offsets
`define PDCG_OFS_DIV_SRC 8'h1c
`define PDCG_OFS_PLL_CTRL 8'h20
`define PDCG_OFS_DIV_CTRL 8'h24
`define PDCG_OFS_GATE1 8'h30
`define PDCG_OFS_PWM_SEL 8'h34

// Reset values
`define PDCG_RST_DIV_SRC 32'h0000_000c
`define PDCG_RST_PLL_CTRL 32'h0000_c22e
`define PDCG_RST_DIV_CTRL 32'h0000_0000
`define PDCG_RST_GATE1 32'h0000_0000
`define PDCG_RST_PWM_SEL 32'h000f_003f

// Writable bits of each register
`define PDCG_MSK_DIV_SRC 32'h0000_000c
`define PDCG_MSK_PLL_CTRL 32'h0000_ffff
`define PDCG_MSK_DIV_CTRL 32'h0000_003f
`define PDCG_MSK_GATE1 32'h000f_0700
`define PDCG_MSK_PWM_SEL 32'h000f_0000

// PLL control fields
`define PDCG_PLL_OUT_HI 15
`define PDCG_PLL_OUT_LO 14
`define PDCG_PLL_IN_HI 13
`define PDCG_PLL_IN_LO 9
`define PDCG_PLL_FB_HI 8
`define PDCG_PLL_FB_LO 0
`define PDCG_PLL_RATIO_OFS 2

// Divider control fields
`define PDCG_DIV_SEL_HI 3
`define PDCG_DIV_SEL_LO 0
`define PDCG_DIV_EN_BIT 4
`define PDCG_DIV_BYP_BIT 5

// Divider source select field and codes
`define PDCG_DSRC_HI 3
`define PDCG_DSRC_LO 2
`define PDCG_DSRC_XTAL 2'b00
`define PDCG_DSRC_RSVD 2'b01
`define PDCG_DSRC_BUS 2'b10
`define PDCG_DSRC_HIRC 2'b11

// Gate and select field positions
`define PDCG_PWM_LO 16
`define PDCG_PWM_HI 19
`define PDCG_UART_LO 8
`define PDCG_UART_HI 10

`endif

/* File: pdcg_periph.sv */
// Model of the clock sources and of the peripherals counting clock edges
`default_nettype none
module pdcg_periph
(
  // Inputs
  input wire logic sys_clk_i,
  input wire logic clr_i,
  input wire logic [7:0] clk_in_i,
  // Sources and edge counts
  output var logic xtal_clk_o,
  output var logic hirc_clk_o,
  output var logic bus_clk_o,
  output var logic pll_clk_o,
  output var logic pclk_o,
  output var logic [15:0] cnt_o [13]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] now;
  logic [12:0] prev_ff;
  initial
  begin
    {xtal_clk_o, hirc_clk_o, bus_clk_o, pll_clk_o, pclk_o} = 5'h0;
  end
  // Sources never stop, so every switch finds both running
  always #41.3 xtal_clk_o = ~xtal_clk_o;
  always #47.7 hirc_clk_o = ~hirc_clk_o;
  always #53.1 bus_clk_o = ~bus_clk_o;
  always #59.9 pll_clk_o = ~pll_clk_o;
  always #66.7 pclk_o = ~pclk_o;
  assign now = {clk_in_i, pclk_o, pll_clk_o, bus_clk_o, hirc_clk_o, xtal_clk_o};
  always @(posedge sys_clk_i)
  begin
    prev_ff <= now;
    for (int i = 0; i < 13; i++)
      cnt_o[i] <= clr_i ? 16'h0 : cnt_o[i] + 16'(now[i] & ~prev_ff[i]);
  end
endmodule
`default_nettype wire

/* File: pdcg_props.sv */
// Checker for the bus handshake, PLL ratio outputs and clock gates
`default_nettype none
module pdcg_props
(
  // Clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Ratios and clocks
  input wire logic [5:0] input_divide_ratio_o,
  input wire logic [9:0] feedback_multiply_ratio_o,
  input wire logic [2:0] output_divide_ratio_o,
  input wire logic [1:0] pll_output_divide_field_o,
  input wire logic [4:0] pll_input_divide_field_o,
  input wire logic [8:0] pll_feedback_divide_field_o,
  input wire logic [3:0] pwm_engine_clk_o,
  input wire logic [2:0] serial_port_clk_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic req = avs_read_i | avs_write_i;
  logic [6:0] gate_ff;
  // Gate bits as software wrote them, lane by lane
  always @(posedge sys_clk_i)
    if (srst_i)
      gate_ff <= 7'h0;
    else if (avs_write_i && !avs_waitrequest_o && ce_i && avs_address_i == 8'h30)
    begin
      if (avs_byteenable_i[1])
        gate_ff[2:0] <= avs_writedata_i[10:8];
      if (avs_byteenable_i[2])
        gate_ff[6:3] <= avs_writedata_i[19:16];
    end
  logic pwm_b_prev_ff;
  logic [3:0] run_ff;
  // Length of the present level run of engine b's clock, saturating
  always @(posedge sys_clk_i)
  begin
    pwm_b_prev_ff <= pwm_engine_clk_o[1];
    if (srst_i || pwm_engine_clk_o[1] != pwm_b_prev_ff)
      run_ff <= 4'h1;
    else if (run_ff != 4'hf)
      run_ff <= run_ff + 4'h1;
  end
  property p_pwm_pulse;
    pwm_engine_clk_o[1] != pwm_b_prev_ff |-> run_ff >= 4'h3;
  endproperty
  a_pwm_pulse: assert property (p_pwm_pulse) else $error("runt pulse on pwm clock");
  property p_wait_first;
    req && !$past(req) |-> avs_waitrequest_o;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
  property p_wait_ans;
    req && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("late bus answer");
  property p_in_ratio;
    input_divide_ratio_o != 6'h0 |-> input_divide_ratio_o == pll_input_divide_field_o + 6'h2;
  endproperty
  a_in_ratio: assert property (p_in_ratio) else $error("bad input ratio");
  property p_fb_ratio;
    feedback_multiply_ratio_o != 10'h0
      |-> feedback_multiply_ratio_o == pll_feedback_divide_field_o + 10'h2;
  endproperty
  a_fb_ratio: assert property (p_fb_ratio) else $error("bad feedback ratio");
  property p_out_ratio;
    output_divide_ratio_o != 3'h0 |-> output_divide_ratio_o ==
      (pll_output_divide_field_o == 2'h0 ? 3'h1 : pll_output_divide_field_o == 2'h3 ? 3'h4 : 3'h2);
  endproperty
  a_out_ratio: assert property (p_out_ratio) else $error("bad output ratio");
  property p_init;
    $fell(srst_i) |-> ##2 input_divide_ratio_o == 6'h3 && feedback_multiply_ratio_o == 10'h30
      && output_divide_ratio_o == 3'h4;
  endproperty
  a_init: assert property (p_init) else $error("bad ratios after reset");
  property p_ser_gate;
    (serial_port_clk_o & ~$past(serial_port_clk_o) & ~$past(gate_ff[2:0], 2)) == 3'h0;
  endproperty
  a_ser_gate: assert property (p_ser_gate) else $error("serial clock while gated");
  property p_pwm_gate;
    (pwm_engine_clk_o & ~$past(pwm_engine_clk_o) & ~$past(gate_ff[6:3], 2)) == 4'h0;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm clock while gated");
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_ser: cover property ($rose(serial_port_clk_o[1]));
  c_pwm: cover property ($rose(pwm_engine_clk_o[3]));
endmodule
`default_nettype wire

/* File: pdcg_top.v */
// Clock control: PLL ratios, frequency divider output and peripheral clock gating
//
// Decided for this implementation: register access over Avalon-MM.
`default_nettype none
`include "pdcg_map.vh"

module pdcg_top
(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire srst_i,
  input wire ce_i,
  // Avalon-MM slave
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire avs_waitrequest_o,
  output reg [31:0] avs_readdata_o,
  // Source clock levels from outside this clock domain
  input wire xtal_clk_i,
  input wire hirc_clk_i,
  input wire bus_clk_i,
  input wire pll_clk_i,
  input wire pclk_i,
  // PLL ratio outputs
  output reg [5:0] input_divide_ratio_o,
  output reg [9:0] feedback_multiply_ratio_o,
  output reg [2:0] output_divide_ratio_o,
  output reg [1:0] pll_output_divide_field_o,
  output reg [4:0] pll_input_divide_field_o,
  output reg [8:0] pll_feedback_divide_field_o,
  // Generated clocks
  output reg divider_clk_o,
  output wire [3:0] pwm_engine_clk_o,
  output wire [2:0] serial_port_clk_o
);

  // Register file
  reg [31:0] div_src_ff;
  reg [31:0] pll_ctrl_ff;
  reg [31:0] div_ctrl_ff;
  reg [31:0] gate1_ff;
  reg [31:0] pwm_sel_ff;

  // Bus handshake
  reg ack_ff;
  wire req = avs_read_i | avs_write_i;
  wire take = req & ack_ff;
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // One wait state per access: request taken at the second edge
  assign avs_waitrequest_o = req & ~ack_ff;

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ack_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_ff <= req & ~ack_ff;
    end
  end

  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] be;
    input [31:0] wmask;
    begin
      merge = ((old_val & ~be) | (new_val & be)) & wmask;
    end
  endfunction

  wire wr_take = take & avs_write_i;

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      div_src_ff <= `PDCG_RST_DIV_SRC;
      pll_ctrl_ff <= `PDCG_RST_PLL_CTRL;
      div_ctrl_ff <= `PDCG_RST_DIV_CTRL;
      gate1_ff <= `PDCG_RST_GATE1;
      pwm_sel_ff <= `PDCG_RST_PWM_SEL;
    end
    else if (ce_i && wr_take)
    begin
      case (avs_address_i)
        `PDCG_OFS_DIV_SRC:
        begin
          div_src_ff <= merge(div_src_ff, avs_writedata_i, be_mask, `PDCG_MSK_DIV_SRC);
        end
        `PDCG_OFS_PLL_CTRL:
        begin
          pll_ctrl_ff <= merge(pll_ctrl_ff, avs_writedata_i, be_mask, `PDCG_MSK_PLL_CTRL);
        end
        `PDCG_OFS_DIV_CTRL:
        begin
          div_ctrl_ff <= merge(div_ctrl_ff, avs_writedata_i, be_mask, `PDCG_MSK_DIV_CTRL);
        end
        `PDCG_OFS_GATE1:
        begin
          gate1_ff <= merge(gate1_ff, avs_writedata_i, be_mask, `PDCG_MSK_GATE1);
        end
        `PDCG_OFS_PWM_SEL:
        begin
          pwm_sel_ff <= merge(pwm_sel_ff, avs_writedata_i, be_mask, `PDCG_MSK_PWM_SEL);
        end
        default:
        begin
          div_src_ff <= div_src_ff;
        end
      endcase
    end
  end

  // Read data; unmapped addresses read zero
  reg [31:0] nxt_rdata;

  always @*
  begin
    case (avs_address_i)
      `PDCG_OFS_DIV_SRC: nxt_rdata = div_src_ff;
      `PDCG_OFS_PLL_CTRL: nxt_rdata = pll_ctrl_ff;
      `PDCG_OFS_DIV_CTRL: nxt_rdata = div_ctrl_ff;
      `PDCG_OFS_GATE1: nxt_rdata = gate1_ff;
      `PDCG_OFS_PWM_SEL: nxt_rdata = pwm_sel_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (ce_i && req && !ack_ff && avs_read_i)
    begin
      avs_readdata_o <= nxt_rdata;
    end
  end

  // PLL ratio decode
  wire [1:0] out_fld = pll_ctrl_ff[`PDCG_PLL_OUT_HI:`PDCG_PLL_OUT_LO];
  wire [4:0] in_fld = pll_ctrl_ff[`PDCG_PLL_IN_HI:`PDCG_PLL_IN_LO];
  wire [8:0] fb_fld = pll_ctrl_ff[`PDCG_PLL_FB_HI:`PDCG_PLL_FB_LO];
  wire [31:0] in_sum = {27'h000_0000, in_fld} + `PDCG_PLL_RATIO_OFS;
  wire [31:0] fb_sum = {23'h00_0000, fb_fld} + `PDCG_PLL_RATIO_OFS;
  reg [2:0] nxt_out_ratio;

  always @*
  begin
    case (out_fld)
      2'b00: nxt_out_ratio = 3'h1;
      2'b01: nxt_out_ratio = 3'h2;
      2'b10: nxt_out_ratio = 3'h2;
      2'b11: nxt_out_ratio = 3'h4;
      default: nxt_out_ratio = 3'h1;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      input_divide_ratio_o <= 6'h00;
      feedback_multiply_ratio_o <= 10'h000;
      output_divide_ratio_o <= 3'h0;
      pll_output_divide_field_o <= 2'h0;
      pll_input_divide_field_o <= 5'h00;
      pll_feedback_divide_field_o <= 9'h000;
    end
    else if (ce_i)
    begin
      input_divide_ratio_o <= in_sum[5:0];
      feedback_multiply_ratio_o <= fb_sum[9:0];
      output_divide_ratio_o <= nxt_out_ratio;
      pll_output_divide_field_o <= out_fld;
      pll_input_divide_field_o <= in_fld;
      pll_feedback_divide_field_o <= fb_fld;
    end
  end

  // Two-stage synchronisers for the source clock levels
  wire [4:0] pins = {pclk_i, pll_clk_i, bus_clk_i, hirc_clk_i, xtal_clk_i};
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end
    else if (ce_i)
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  wire xtal_s = sync2_ff[0];
  wire hirc_s = sync2_ff[1];
  wire bus_s = sync2_ff[2];
  wire pll_s = sync2_ff[3];
  wire pclk_s = sync2_ff[4];

  // Frequency divider source
  wire [1:0] divider_source_select = div_src_ff[`PDCG_DSRC_HI:`PDCG_DSRC_LO];
  reg div_src_lvl;

  always @*
  begin
    case (divider_source_select)
      `PDCG_DSRC_XTAL: div_src_lvl = xtal_s;
      `PDCG_DSRC_BUS: div_src_lvl = bus_s;
      `PDCG_DSRC_HIRC: div_src_lvl = hirc_s;
      default: div_src_lvl = 1'b0;
    endcase
  end

  wire [3:0] divider_power_select = div_ctrl_ff[`PDCG_DIV_SEL_HI:`PDCG_DIV_SEL_LO];
  wire divider_enable = div_ctrl_ff[`PDCG_DIV_EN_BIT];
  wire divide_bypass = div_ctrl_ff[`PDCG_DIV_BYP_BIT];

  reg src_prev_ff;
  reg [14:0] div_cnt_ff;
  reg div_tgl_ff;
  reg div_active_ff;
  reg div_byp_ff;
  wire src_rise = div_src_lvl & ~src_prev_ff;
  wire src_fall = ~div_src_lvl & src_prev_ff;
  wire div_change = (divider_enable != div_active_ff) |
                    (divider_enable & (divide_bypass != div_byp_ff));
  wire [14:0] sel_mask = (15'h0001 << divider_power_select) - 15'h0001;
  reg nxt_div_clk;

  always @*
  begin
    nxt_div_clk = 1'b0;
    if (div_active_ff)
    begin
      nxt_div_clk = div_byp_ff ? div_src_lvl : div_tgl_ff;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      src_prev_ff <= 1'b0;
      div_cnt_ff <= 15'h0000;
      div_tgl_ff <= 1'b0;
      div_active_ff <= 1'b0;
      div_byp_ff <= 1'b0;
      divider_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      src_prev_ff <= div_src_lvl;
      if (!div_active_ff)
      begin
        div_cnt_ff <= 15'h0000;
        div_tgl_ff <= 1'b0;
      end
      else if (src_rise)
      begin
        div_cnt_ff <= div_cnt_ff + 15'h0001;
        if ((div_cnt_ff & sel_mask) == sel_mask)
        begin
          div_tgl_ff <= ~div_tgl_ff;
        end
      end
      // A change first stops the output in a low phase, then restarts it
      // at a source falling edge, so no pulse is cut short
      if (div_change && !divider_clk_o && !nxt_div_clk)
      begin
        if (div_active_ff || !divider_enable)
        begin
          div_active_ff <= 1'b0;
        end
        else if (src_fall)
        begin
          div_active_ff <= 1'b1;
          div_byp_ff <= divide_bypass;
        end
        divider_clk_o <= 1'b0;
      end
      else
      begin
        divider_clk_o <= nxt_div_clk;
      end
    end
  end

  // PWM engine clocks: gate and source per engine
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pwm
      pdcg_clk_gate u_pwm_gate
      (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .gate_en_i(gate1_ff[`PDCG_PWM_LO + gi]),
        .src_sel_i(pwm_sel_ff[`PDCG_PWM_LO + gi]),
        .rst_sel_i(1'b1),
        .src0_i(pll_s),
        .src1_i(pclk_s),
        .clk_o(pwm_engine_clk_o[gi])
      );
    end
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_uart
      pdcg_clk_gate u_uart_gate
      (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .gate_en_i(gate1_ff[`PDCG_UART_LO + gi]),
        .src_sel_i(1'b1),
        .rst_sel_i(1'b1),
        .src0_i(pclk_s),
        .src1_i(pclk_s),
        .clk_o(serial_port_clk_o[gi])
      );
    end
  endgenerate

endmodule

`default_nettype wire

/* File: tb.sv */
// Testbench of the clock control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] avs_address_i = 8'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic clr = 1'b1;
  logic [15:0] cnt [13];
  wire logic avs_waitrequest_o, xtal_clk_i, hirc_clk_i, bus_clk_i, pll_clk_i, pclk_i;
  wire logic divider_clk_o;
  wire logic [31:0] avs_readdata_o;
  wire logic [5:0] input_divide_ratio_o;
  wire logic [9:0] feedback_multiply_ratio_o;
  wire logic [2:0] output_divide_ratio_o, serial_port_clk_o;
  wire logic [1:0] pll_output_divide_field_o;
  wire logic [4:0] pll_input_divide_field_o;
  wire logic [8:0] pll_feedback_divide_field_o;
  wire logic [3:0] pwm_engine_clk_o;
  int mismatches = 0;
  int checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  pdcg_top DUT (.*);
  pdcg_periph u_periph (.sys_clk_i(sys_clk_i), .clr_i(clr),
    .clk_in_i({serial_port_clk_o, pwm_engine_clk_o, divider_clk_o}), .xtal_clk_o(xtal_clk_i),
    .hirc_clk_o(hirc_clk_i), .bus_clk_o(bus_clk_i), .pll_clk_o(pll_clk_i), .pclk_o(pclk_i),
    .cnt_o(cnt));
  task conclude;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Edge counts may differ by window alignment and synchroniser delay
  task chk_near(input string nm, input int e, input logic [15:0] g);
    checked++;
    if ($isunknown(g) || int'(g) > e + 2 || int'(g) < e - 2)
    begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= b;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0)
    begin
      mismatches++;
      $display("wrong value waitrequest expected 0 seen 1");
      conclude;
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask
  task measure;
    @(posedge sys_clk_i);
    clr <= 1'b1;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    repeat (3000) @(posedge sys_clk_i);
  endtask
  task t_reset;
    chk("in_ratio", 32'h3, {26'h0, input_divide_ratio_o});
    chk("fb_ratio", 32'h30, {22'h0, feedback_multiply_ratio_o});
    chk("out_ratio", 32'h4, {29'h0, output_divide_ratio_o});
    rdc("div_ctrl", 8'h24, 32'h0);
    rdc("gate", 8'h30, 32'h0);
    rdc("pwm_sel", 8'h34, 32'h000f_003f);
    rdc("pll_ctrl", 8'h20, 32'h0000_c22e);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("div_src", 8'h1c, 32'h0000_000c);
  endtask
  task t_pll;
    logic [31:0] tbl [4];
    logic [31:0] q;
    logic [2:0] no;
    // Reference taken as 12 MHz; every setting keeps the core at 144 to 192 MHz
    tbl = '{32'h0000_001c, 32'h0000_7fff, 32'h0000_8a52, 32'h0000_c22e};
    foreach (tbl[i])
    begin
      bus(1'b1, 8'h20, tbl[i], 4'hf, q);
      rdc("pll_ctrl", 8'h20, tbl[i]);
      no = tbl[i][15:14] == 2'h0 ? 3'h1 : tbl[i][15:14] == 2'h3 ? 3'h4 : 3'h2;
      chk("in_ratio", {27'h0, tbl[i][13:9]} + 32'h2, {26'h0, input_divide_ratio_o});
      chk("fb_ratio", {23'h0, tbl[i][8:0]} + 32'h2, {22'h0, feedback_multiply_ratio_o});
      chk("out_ratio", {29'h0, no}, {29'h0, output_divide_ratio_o});
      chk("fields", tbl[i], {16'h0, pll_output_divide_field_o, pll_input_divide_field_o,
        pll_feedback_divide_field_o});
    end
    bus(1'b1, 8'h20, 32'h0000_ff24, 4'h1, q);
    rdc("pll_lane", 8'h20, 32'h0000_c224);
  endtask
  task t_div(input logic [1:0] src, input logic [5:0] ctl);
    logic [31:0] q;
    int c;
    int e;
    bus(1'b1, 8'h1c, {28'h0, src, 2'h0}, 4'hf, q);
    bus(1'b1, 8'h24, {26'h0, ctl}, 4'hf, q);
    measure;
    c = src == 2'h0 ? cnt[0] : src == 2'h2 ? cnt[2] : cnt[1];
    e = (!ctl[4] || src == 2'h1) ? 0 : ctl[5] ? c : c >> (ctl[3:0] + 1);
    chk_near("divider_edges", e, cnt[5]);
  endtask
  // Clock enable low must freeze the running divider
  task t_freeze;
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    measure;
    chk_near("frozen_edges", 0, cnt[5]);
    ce_i <= 1'b1;
  endtask
  task t_gate(input logic [3:0] sel, input logic [3:0] pg, input logic [2:0] ug);
    logic [31:0] q;
    bus(1'b1, 8'h34, {12'h0, sel, 16'h0}, 4'hf, q);
    bus(1'b1, 8'h30, {12'h0, pg, 5'h0, ug, 8'h0}, 4'hf, q);
    measure;
    for (int i = 0; i < 3; i++)
      chk_near("serial_edges", ug[i] ? cnt[4] : 0, cnt[10 + i]);
    for (int i = 0; i < 4; i++)
      chk_near("pwm_edges", pg[i] ? (sel[i] ? cnt[4] : cnt[3]) : 0, cnt[6 + i]);
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    t_reset;
    t_pll;
    t_div(2'h0, 6'h11);
    t_div(2'h0, 6'h14);
    t_div(2'h0, 6'h31);
    t_div(2'h0, 6'h01);
    t_div(2'h1, 6'h10);
    t_div(2'h2, 6'h10);
    t_div(2'h3, 6'h10);
    t_freeze;
    t_gate(4'h5, 4'hf, 3'h7);
    t_gate(4'h3, 4'ha, 3'h2);
    t_gate(4'h0, 4'h0, 3'h0);
    conclude;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    mismatches++;
    conclude;
  end
endmodule
bind pdcg_top pdcg_props u_props (.*);
`default_nettype wire
